// ==== hw/peripheral_interrupt_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_map.svh"
module peripheral_interrupt_flags import irq_flags_pkg::*; (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // peripheral event pulses, bit positions as flag register 1
  input  wire logic [7:0]  events1_in,
  // oscillator, comparators, eeprom, collision at bits 7..3
  input  wire logic [7:0]  events2_in,
  // core events: timer0, pin, change at bits 2..0
  input  wire logic [2:0]  core_events_in,
  // serial unit state levels
  input  wire logic        serial_rx_pending_in,
  input  wire logic        serial_tx_pending_in,
  // interrupt outputs
  output logic             cpu_irq_out,
  output logic             irq_out
);
  // ************************************************************
  // flag banks
  // ************************************************************
  flag_if f1 ();
  flag_if f2 ();
  flag_if fc ();

  flag_bank #(.IMPL(`FLAGS1_WMASK), .WMASK(`FLAGS1_WMASK)) u_flags1 (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .port     (f1)
  );
  flag_bank #(.IMPL(`FLAGS2_IMPL), .WMASK(`FLAGS2_IMPL)) u_flags2 (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .port     (f2)
  );
  flag_bank #(.IMPL(`CTRL_CORE_FLAGS), .WMASK(`CTRL_CORE_FLAGS)) u_core (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .port     (fc)
  );

  // ************************************************************
  // registers
  // ************************************************************
  bus_state_t  state_r;
  bus_state_t  state_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  byte_t       ser_r;
  byte_t       ser_nxt;
  byte_t       ctrl_r;
  byte_t       ctrl_nxt;
  byte_t       en1_r;
  byte_t       en1_nxt;
  byte_t       en2_r;
  byte_t       en2_nxt;
  byte_t       stat_r;
  byte_t       stat_nxt;
  byte_t       mask_r;
  byte_t       mask_nxt;
  logic        cpu_irq_r;
  logic        cpu_irq_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        waitreq_r;
  logic        waitreq_nxt;

  function automatic logic hit(input logic [4:0] a, input logic [2:0] idx);
    hit = (a[4:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  logic        wr_go;
  logic        lane0;
  byte_t       wbyte;
  byte_t       flags1_view;
  byte_t       ctrl_view;
  logic        pend;
  logic        req;

  always_comb begin
    wr_go = avs_write_in && (state_r == st_idle);
    lane0 = avs_byteenable_in[0];
    wbyte = avs_writedata_in[7:0];
    // serial flags mirror the serial unit, not software
    flags1_view = f1.value; // RULE4
    flags1_view[`FLAGS1_SER_RX] = ser_r[`FLAGS1_SER_RX]; // RULE5
    flags1_view[`FLAGS1_SER_TX] = ser_r[`FLAGS1_SER_TX]; // RULE5
    ctrl_view = (ctrl_r & ~`CTRL_CORE_FLAGS) | fc.value; // RULE10
    pend = |(flags1_view & en1_r) || |(f2.value & en2_r); // RULE10
    // core sources need no peripheral enable
    req = ctrl_r[`CTRL_GIE] &&
          ((ctrl_r[`CTRL_PERIPHERAL_IRQ_ENABLE] && pend) || |(fc.value[2:0] & ctrl_r[5:3])); // RULE11 RULE12
  end

  always_comb begin
    f1.set     = events1_in & `FLAGS1_WMASK; // RULE1
    f1.wr_en   = (wr_go && lane0 && hit(avs_address_in, `IDX_FLAGS1)) ? 8'hff : 8'h00; // RULE6
    f1.wr_data = wbyte;
    f2.set     = events2_in & `FLAGS2_IMPL; // RULE8
    f2.wr_en   = (wr_go && lane0 && hit(avs_address_in, `IDX_FLAGS2)) ? 8'hff : 8'h00;
    f2.wr_data = wbyte;
    fc.set     = {5'h00, core_events_in};
    fc.wr_en   = (wr_go && lane0 && hit(avs_address_in, `IDX_CONTROL)) ? 8'hff : 8'h00;
    fc.wr_data = wbyte;
  end

  // ************************************************************
  // bus and control next state
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    ser_nxt   = `RESET_BYTE;
    ctrl_nxt  = ctrl_r;
    en1_nxt   = en1_r;
    en2_nxt   = en2_r;
    stat_nxt  = stat_r;
    mask_nxt  = mask_r;
    ser_nxt[`FLAGS1_SER_RX] = serial_rx_pending_in;
    ser_nxt[`FLAGS1_SER_TX] = serial_tx_pending_in;
    // one wait cycle per access: request taken in idle, answered in ack
    unique case (state_r)
      st_idle: begin
        if (avs_read_in || avs_write_in) begin
          state_nxt = st_ack;
        end
        rdata_nxt = `ZERO_WORD;
        if (avs_read_in) begin
          if (hit(avs_address_in, `IDX_FLAGS1)) rdata_nxt[7:0] = flags1_view;
          if (hit(avs_address_in, `IDX_FLAGS2)) rdata_nxt[7:0] = f2.value; // RULE9
          if (hit(avs_address_in, `IDX_CONTROL)) rdata_nxt[7:0] = ctrl_view;
          if (hit(avs_address_in, `IDX_ENABLES1)) rdata_nxt[7:0] = en1_r;
          if (hit(avs_address_in, `IDX_ENABLES2)) rdata_nxt[7:0] = en2_r;
          if (hit(avs_address_in, `IDX_IRQ_STATUS)) rdata_nxt[7:0] = stat_r;
          if (hit(avs_address_in, `IDX_IRQ_MASK)) rdata_nxt[7:0] = mask_r;
        end
        if (wr_go && lane0) begin
          if (hit(avs_address_in, `IDX_CONTROL)) begin
            ctrl_nxt = wbyte & ~`CTRL_CORE_FLAGS; // RULE10
          end
          if (hit(avs_address_in, `IDX_ENABLES1)) en1_nxt = wbyte; // RULE10
          if (hit(avs_address_in, `IDX_ENABLES2)) en2_nxt = wbyte & `FLAGS2_IMPL;
          if (hit(avs_address_in, `IDX_IRQ_STATUS)) stat_nxt = stat_r & ~wbyte;
          if (hit(avs_address_in, `IDX_IRQ_MASK)) mask_nxt = wbyte & `STAT_MASK;
        end
      end
      st_ack: begin
        state_nxt = st_idle;
      end
    endcase
    // hardware set wins over write-one-to-clear
    if (req && !cpu_irq_r) stat_nxt[`STAT_REQ_RISE] = 1'b1;
    if (|events1_in || |events2_in || |core_events_in) stat_nxt[`STAT_FLAG_SET] = 1'b1;
    stat_nxt    = stat_nxt & `STAT_MASK;
    cpu_irq_nxt = req; // RULE12
    irq_nxt     = |(stat_nxt & mask_nxt);
    // registered so the bus sees no decode glitch on waitrequest
    waitreq_nxt = (state_nxt != st_ack);
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r   <= st_idle;
      rdata_r   <= `ZERO_WORD;
      ser_r     <= `RESET_BYTE; // RULE7
      ctrl_r    <= `RESET_BYTE;
      en1_r     <= `RESET_BYTE;
      en2_r     <= `RESET_BYTE;
      stat_r    <= `RESET_BYTE;
      mask_r    <= `RESET_BYTE;
      cpu_irq_r <= 1'b0;
      irq_r     <= 1'b0;
      waitreq_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      rdata_r   <= rdata_nxt;
      ser_r     <= ser_nxt;
      ctrl_r    <= ctrl_nxt;
      en1_r     <= en1_nxt;
      en2_r     <= en2_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      cpu_irq_r <= cpu_irq_nxt;
      irq_r     <= irq_nxt;
      waitreq_r <= waitreq_nxt;
    end
  end

  // waitrequest is low only in the ack cycle
  assign avs_waitrequest_out = waitreq_r;
  assign avs_readdata_out = rdata_r;
  assign cpu_irq_out      = cpu_irq_r;
  assign irq_out          = irq_r;
endmodule
`default_nettype wire

// ==== hw/irq_flags_map.svh ====
// Functional notes
// (RULE1) flags set on event regardless of enables
// (RULE2) software clears flags before enabling sources
// (RULE3) flag reads one when pending
// (RULE4) first flag register bit layout fixed
// (RULE5) serial receive/transmit flags follow serial unit
// (RULE6) other flags software readable and writable
// (RULE7) all flags reset to zero
// (RULE8) second flag register bits seven to three
// (RULE9) second register bits two..zero read zero
// (RULE10) enables mirror flag positions; control layout
// (RULE11) peripheral enable gates all peripheral sources
// (RULE12) request when flag, enable, peripheral_irq_enable, gie set
`ifndef IRQ_FLAGS_MAP_SVH
`define IRQ_FLAGS_MAP_SVH

// ************************************************************
// register word indices (byte address = index * 4)
// ************************************************************
`define IDX_FLAGS1      3'h0
`define IDX_FLAGS2      3'h1
`define IDX_CONTROL     3'h2
`define IDX_ENABLES1    3'h3
`define IDX_ENABLES2    3'h4
`define IDX_IRQ_STATUS  3'h5
`define IDX_IRQ_MASK    3'h6

// ************************************************************
// field layout
// ************************************************************
`define RESET_BYTE      8'h00
`define FLAGS1_WMASK    8'hcf
`define FLAGS1_SER_RX   5
`define FLAGS1_SER_TX   4
`define FLAGS2_IMPL     8'hf8
`define CTRL_GIE        7
`define CTRL_PERIPHERAL_IRQ_ENABLE       6
`define CTRL_WMASK      8'hff
`define CTRL_CORE_FLAGS 8'h07
`define STAT_MASK       8'h03
`define STAT_REQ_RISE   0
`define STAT_FLAG_SET   1
`define ZERO_WORD       32'h0000_0000

`endif

// ==== hw/irq_flags_pkg.sv ====
package irq_flags_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_ack  = 2'b01
  } bus_state_t;
endpackage

// ==== hw/flag_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface flag_if;
  logic [7:0] set;
  logic [7:0] wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;
  modport owner (input set, input wr_en, input wr_data, output value);
  modport user (output set, output wr_en, output wr_data, input value);
endinterface
`default_nettype wire

// ==== hw/flag_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "irq_flags_map.svh"
module flag_bank import irq_flags_pkg::*; #(
  parameter byte_t IMPL  = 8'hff,
  parameter byte_t WMASK = 8'hff
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  flag_if.owner     port
);
  byte_t flags_r;
  byte_t flags_nxt;

  // set beats a same-cycle software write of zero
  always_comb begin
    flags_nxt = flags_r;
    for (int i = 0; i < 8; i++) begin
      if (port.wr_en[i] && WMASK[i]) begin
        flags_nxt[i] = port.wr_data[i]; // RULE6
      end
      if (port.set[i]) begin
        flags_nxt[i] = 1'b1; // RULE1
      end
    end
    flags_nxt = flags_nxt & IMPL; // RULE9
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_r <= `RESET_BYTE; // RULE7
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign port.value = flags_r; // RULE3
endmodule
`default_nettype wire

// ==== tb/event_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        fire_in,
  input  wire logic [18:0] pat_in,
  output logic      [18:0] ev_out
);
  // pat_in is driven for every cycle fire_in is high; the testbench fires for one cycle, so a flag can come from no other edge
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ev_out <= 19'h0;
    end else begin
      ev_out <= fire_in ? pat_in : 19'h0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/irq_flags_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_flags_checker (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        serial_rx_pending_in,
  input wire logic        serial_tx_pending_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic       ack;
  logic       rd_ack;
  logic [1:0] ser;
  assign ack = !avs_waitrequest_out;
  assign rd_ack = ack && avs_read_in;
  assign ser = {serial_rx_pending_in, serial_tx_pending_in};
  a_ack_after_take: assert property ((avs_read_in || avs_write_in) && !ack |=> ack)
    else $error("request not answered");
  a_ack_one_cycle: assert property (ack |=> !ack) else $error("ack too long");
  a_ack_has_cause: assert property (ack |-> $past(avs_read_in || avs_write_in))
    else $error("ack without request");
  a_upper_zero: assert property (ack |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  a_flags2_low_zero: assert property (
    rd_ack && avs_address_in == 5'h04 |-> avs_readdata_out[2:0] == 3'h0)
    else $error("unimplemented bits read one");
  a_misaligned_zero: assert property (
    rd_ack && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0)
    else $error("misaligned read not zero");
  a_unmapped_zero: assert property (
    rd_ack && avs_address_in[4:2] == 3'h7 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_serial_follow: assert property (
    rd_ack && avs_address_in == 5'h00 && $past(ser) == $past(ser, 2)
    |-> avs_readdata_out[5:4] == $past(ser))
    else $error("serial flags do not follow state");
endmodule
bind peripheral_interrupt_flags irq_flags_checker checker_inst (.*);
`default_nettype wire

// ==== tb/peripheral_interrupt_flags_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_flags_tb_top import irq_flags_pkg::*;;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic rx = 1'b0;
  logic tx = 1'b0;
  logic fire = 1'b0;
  logic [18:0] pat = 19'h0;
  logic [18:0] ev;
  logic [31:0] rdata;
  logic wreq;
  logic cpu_irq;
  logic irq;
  int n_errors = 0;
  int checked = 0;
  byte_t p1, p2, q;
  always #2.5 clk_in = ~clk_in;
  event_source_model event_source_model_inst (.clk_in(clk_in), .reset_in(reset_in),
    .fire_in(fire), .pat_in(pat), .ev_out(ev));
  peripheral_interrupt_flags peripheral_interrupt_flags_inst (.clk_in(clk_in),
    .reset_in(reset_in), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .events1_in(ev[7:0]), .events2_in(ev[15:8]),
    .core_events_in(ev[18:16]), .serial_rx_pending_in(rx),
    .serial_tx_pending_in(tx), .cpu_irq_out(cpu_irq), .irq_out(irq));
  task automatic give_verdict();
    $display("errors %0d checked %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input byte_t d);
    int n;
    @(posedge clk_in);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      give_verdict();
    end
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input logic [4:0] a, input byte_t e);
    bus(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  task automatic pulse(input logic [18:0] p);
    @(posedge clk_in);
    fire <= 1'b1;
    pat <= p;
    @(posedge clk_in);
    fire <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  initial begin
    void'($urandom(41));
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 8; i++) chk(5'(i * 4), 8'h00);
    $display("reset test done");
    p1 = byte_t'($urandom) | 8'h01;
    p2 = byte_t'($urandom);
    pulse({3'h5, p2, p1});
    chk(5'h00, p1 & 8'hcf);
    chk(5'h04, p2 & 8'hf8);
    chk(5'h08, 8'h05);
    `CHK(cpu_irq, 1'b0)
    $display("event test done");
    rx <= 1'b1;
    tx <= 1'b1;
    bus(1'b1, 5'h00, 8'hff);
    chk(5'h00, 8'hff);
    bus(1'b1, 5'h00, 8'h00);
    chk(5'h00, 8'h30);
    bus(1'b1, 5'h04, 8'hff);
    chk(5'h04, 8'hf8);
    be <= 4'he;
    bus(1'b1, 5'h04, 8'h00);
    be <= 4'hf;
    chk(5'h04, 8'hf8);
    bus(1'b1, 5'h04, 8'h00);
    p1 = byte_t'($urandom);
    bus(1'b1, 5'h0c, p1);
    chk(5'h0c, p1);
    bus(1'b1, 5'h10, 8'hff);
    chk(5'h10, 8'hf8);
    bus(1'b1, 5'h1c, 8'hff);
    chk(5'h1c, 8'h00);
    chk(5'h01, 8'h00);
    $display("register test done");
    rx <= 1'b0;
    tx <= 1'b0;
    bus(1'b1, 5'h0c, 8'h01);
    bus(1'b1, 5'h10, 8'h00);
    bus(1'b1, 5'h08, 8'h80);
    pulse(19'h00001);
    `CHK(cpu_irq, 1'b0)
    bus(1'b1, 5'h08, 8'hc0);
    repeat (2) @(posedge clk_in);
    `CHK(cpu_irq, 1'b1)
    `CHK(irq, 1'b0)
    bus(1'b1, 5'h18, 8'h03);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 1'b1)
    bus(1'b1, 5'h00, 8'h00);
    bus(1'b1, 5'h14, 8'h03);
    repeat (2) @(posedge clk_in);
    `CHK(cpu_irq, 1'b0)
    `CHK(irq, 1'b0)
    chk(5'h14, 8'h00);
    $display("interrupt test done");
    give_verdict();
  end
endmodule
`default_nettype wire
